// [camera_hub_pkg.sv]
// Purpose: Constants and state type of the camera hub configuration bank
// Assumes: 8-bit register port, 250 MHz core clock
// Notes:   Port-scoped registers act on the port picked by port_select

package camera_hub_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_FWD         = 8'h20;
	localparam logic [7:0] ADDR_PORT_SEL    = 8'h4c;
	localparam logic [7:0] ADDR_PORT_CFG    = 8'h6d;
	localparam logic [7:0] ADDR_VCDT_TEN    = 8'h70;
	localparam logic [7:0] ADDR_VCDT_TWELVE = 8'h71;
	localparam logic [7:0] ADDR_PAGE        = 8'hb0;
	localparam logic [7:0] ADDR_INDEX       = 8'hb1;
	localparam logic [7:0] ADDR_DATA        = 8'hb2;
	localparam logic [7:0] ADDR_EQ_STATUS   = 8'hd2;
	localparam logic [7:0] ADDR_EQ_CTRL     = 8'hd3;
	localparam logic [7:0] ADDR_EQ_MIN      = 8'hd4;
	localparam logic [7:0] ADDR_EQ_LEVEL    = 8'hd5;

	// ----------------------------------------
	// Indirect pages, indices and fields
	// ----------------------------------------
	localparam logic [7:0] PAGE_SHARED     = 8'h14;
	localparam logic [7:0] PAGE_PORT_FIRST = 8'h04;
	localparam logic [7:0] PAGE_PORT_LAST  = 8'h10;
	localparam logic [7:0] IDX_MON_EN      = 8'h00;
	localparam logic [7:0] IDX_MON_MUX     = 8'h01;
	localparam logic [7:0] IDX_LOOP_SEL    = 8'h0f;
	localparam logic [7:0] IDX_CML_EN      = 8'h10;
	localparam int         MON_EN_BIT      = 7;
	localparam int         CML_EN_BIT      = 1;
	localparam int         CFG_CABLE_BIT   = 2;
	localparam int         EQ_ADAPT_BIT    = 0;
	localparam int         EQ_LOCK_BIT     = 7;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [7:0] RST_FWD          = 8'h0f;
	localparam logic [7:0] RST_VCDT_TEN     = 8'h2b;
	localparam logic [7:0] RST_VCDT_TWELVE  = 8'h2c;
	localparam logic [7:0] RST_EQ_CTRL      = 8'h01;
	localparam logic [7:0] EQ_LEVEL_MAX     = 8'h3f;
	localparam logic [1:0] STRAP_WAIT       = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_PERIOD_NS    = 4;
	localparam int         ADAPT_STEP_NS    = 1000;
	localparam int         ADAPT_CYCLES     = ADAPT_STEP_NS / CLK_PERIOD_NS;
	localparam logic [7:0] TICK_LAST        = 8'(ADAPT_CYCLES - 1);

	typedef enum logic [1:0] {
		MODE_RESERVED,
		MODE_TWELVE_LF,
		MODE_TWELVE_HF,
		MODE_TEN
	} link_input_mode_t;

	typedef struct packed {
		logic [2:0]      strap_s1;
		logic [2:0]      strap_s2;
		logic [1:0]      strap_wait;
		logic            strap_done;
		logic [3:0]      lock_s1;
		logic [3:0]      lock_s2;
		logic [3:0]      lock_d;
		logic [7:0]      tick_cnt;
		logic            tick;
		logic [1:0]      port_sel;
		logic [7:0]      fwd;
		logic [3:0][7:0] cfg;
		logic [3:0][7:0] vcdt10;
		logic [3:0][7:0] vcdt12;
		logic [3:0][7:0] vcdt_out;
		logic [3:0][7:0] eq_ctl;
		logic [3:0][7:0] eq_min;
		logic [3:0][7:0] eq_lvl;
		logic [3:0]      restart;
		logic [7:0]      page;
		logic [7:0]      idx;
		logic            mon_en;
		logic [3:0]      mon_mux;
		logic [3:0]      loop_sel;
		logic [3:0]      cml_en;
		logic [3:0]      mon_out;
		logic [7:0]      rdata;
	} hub_state_t;

endpackage

// [camera_hub_mode_monitor_config.sv]
// Purpose: Per-port mode, forwarding, equalizer and monitor routing bank
// Assumes: Host register port already decoded from the serial control bus
// Notes:   All timers run from ref_clk_i; power-down pin drives sys_rst_i

`timescale 1ns/100ps

module camera_hub_mode_monitor_config
	import camera_hub_pkg::*;
(
	input  wire logic            ref_clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic [2:0]      mode_strap_i,
	input  wire logic [3:0]      rx_lock_i,
	input  wire logic            reg_wr_i,
	input  wire logic            reg_rd_i,
	input  wire logic [7:0]      reg_addr_i,
	input  wire logic [7:0]      reg_wdata_i,
	output logic      [7:0]      reg_rdata_o,
	output logic                 strap_done_o,
	output logic      [3:0][1:0] link_input_mode_o,
	output logic      [3:0]      cable_type_select_o,
	output logic      [3:0][7:0] raw_vc_dt_o,
	output logic      [3:0]      fwd_enable_o,
	output logic      [3:0]      fwd_target_o,
	output logic      [3:0][7:0] eq_level_o,
	output logic      [3:0]      adaptive_equalizer_restart_o,
	output logic                 monitor_output_enable_o,
	output logic      [3:0]      monitor_port_o
);
	import camera_hub_pkg::*;

	hub_state_t q;
	hub_state_t d;
	logic       pg_hit;
	logic [1:0] pg_port;
	logic [7:0] ind_rdata;

	// ----------------------------------------
	// Indirect page decode
	// ----------------------------------------
	assign pg_hit  = (q.page[1:0] == 2'h0) && (q.page >= PAGE_PORT_FIRST)
		&& (q.page <= PAGE_PORT_LAST);
	assign pg_port = 2'(q.page[4:2] - 3'h1);

	always_comb
	begin
		ind_rdata = 8'h00;
		if (q.page == PAGE_SHARED && q.idx == IDX_MON_EN)
			ind_rdata[MON_EN_BIT] = q.mon_en;
		else if (q.page == PAGE_SHARED && q.idx == IDX_MON_MUX)
			ind_rdata = {4'h0, q.mon_mux};
		else if (pg_hit && q.idx == IDX_LOOP_SEL)
			ind_rdata[0] = q.loop_sel[pg_port];
		else if (pg_hit && q.idx == IDX_CML_EN)
			ind_rdata[CML_EN_BIT] = q.cml_en[pg_port];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.strap_s1 = mode_strap_i;
		d.strap_s2 = q.strap_s1;
		d.lock_s1  = rx_lock_i;
		d.lock_s2  = q.lock_s1;
		d.lock_d   = q.lock_s2;
		d.restart  = 4'h0;
		d.rdata    = 8'h00;

		// Adaptation step timer, counted in core clocks
		d.tick = 1'b0;
		if (q.tick_cnt == TICK_LAST)
		begin
			d.tick_cnt = 8'h00;
			d.tick     = 1'b1;
		end
		else
			d.tick_cnt = q.tick_cnt + 8'h01;

		// Strap sampled once, after it has crossed the synchroniser
		if (!q.strap_done)
		begin
			d.strap_wait = q.strap_wait + 2'h1;
			if (q.strap_wait == STRAP_WAIT)
			begin
				d.strap_done = 1'b1;
				for (int p = 0; p < 4; p++)
					d.cfg[p][2:0] = q.strap_s2;
			end
		end

		// Equalizer restart on lock loss, hunt while unlocked
		for (int p = 0; p < 4; p++)
		begin
			if (q.lock_d[p] && !q.lock_s2[p])
			begin
				d.restart[p] = 1'b1;
				d.eq_lvl[p]  = q.eq_min[p];
			end
			else if (!q.lock_s2[p] && q.eq_ctl[p][EQ_ADAPT_BIT] && q.tick)
			begin
				if (q.eq_lvl[p] >= EQ_LEVEL_MAX)
					d.eq_lvl[p] = q.eq_min[p];
				else
					d.eq_lvl[p] = q.eq_lvl[p] + 8'h01;
			end
		end

		// Host writes; port-scoped ones touch only the selected port
		if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_PORT_SEL)
				d.port_sel = reg_wdata_i[1:0];
			else if (reg_addr_i == ADDR_FWD)
				d.fwd = reg_wdata_i;
			else if (reg_addr_i == ADDR_PORT_CFG)
			begin
				// Dropped until the strap has landed, so it cannot clobber a write
				if (q.strap_done)
					d.cfg[q.port_sel] = reg_wdata_i;
			end
			else if (reg_addr_i == ADDR_VCDT_TEN)
				d.vcdt10[q.port_sel] = reg_wdata_i;
			else if (reg_addr_i == ADDR_VCDT_TWELVE)
				d.vcdt12[q.port_sel] = reg_wdata_i;
			else if (reg_addr_i == ADDR_EQ_CTRL)
				d.eq_ctl[q.port_sel] = reg_wdata_i;
			else if (reg_addr_i == ADDR_EQ_MIN)
				d.eq_min[q.port_sel] = reg_wdata_i;
			else if (reg_addr_i == ADDR_PAGE)
				d.page = reg_wdata_i;
			else if (reg_addr_i == ADDR_INDEX)
				d.idx = reg_wdata_i;
			else if (reg_addr_i == ADDR_DATA)
			begin
				if (q.page == PAGE_SHARED && q.idx == IDX_MON_EN)
					d.mon_en = reg_wdata_i[MON_EN_BIT];
				else if (q.page == PAGE_SHARED && q.idx == IDX_MON_MUX)
					d.mon_mux = reg_wdata_i[3:0];
				else if (pg_hit && q.idx == IDX_LOOP_SEL)
					d.loop_sel[pg_port] = reg_wdata_i[0];
				else if (pg_hit && q.idx == IDX_CML_EN)
					d.cml_en[pg_port] = reg_wdata_i[CML_EN_BIT];
			end
		end

		// Host reads; unmapped offsets return zero
		if (reg_rd_i)
		begin
			if (reg_addr_i == ADDR_PORT_SEL)
				d.rdata = {6'h00, q.port_sel};
			else if (reg_addr_i == ADDR_FWD)
				d.rdata = q.fwd;
			else if (reg_addr_i == ADDR_PORT_CFG)
				d.rdata = q.cfg[q.port_sel];
			else if (reg_addr_i == ADDR_VCDT_TEN)
				d.rdata = q.vcdt10[q.port_sel];
			else if (reg_addr_i == ADDR_VCDT_TWELVE)
				d.rdata = q.vcdt12[q.port_sel];
			else if (reg_addr_i == ADDR_EQ_STATUS)
				d.rdata = {q.lock_s2[q.port_sel], 7'h00};
			else if (reg_addr_i == ADDR_EQ_CTRL)
				d.rdata = q.eq_ctl[q.port_sel];
			else if (reg_addr_i == ADDR_EQ_MIN)
				d.rdata = q.eq_min[q.port_sel];
			else if (reg_addr_i == ADDR_EQ_LEVEL)
				d.rdata = q.eq_lvl[q.port_sel];
			else if (reg_addr_i == ADDR_PAGE)
				d.rdata = q.page;
			else if (reg_addr_i == ADDR_INDEX)
				d.rdata = q.idx;
			else if (reg_addr_i == ADDR_DATA)
				d.rdata = ind_rdata;
		end

		// Header byte follows the port's current mode
		for (int p = 0; p < 4; p++)
		begin
			if (d.cfg[p][1:0] == MODE_TEN)
				d.vcdt_out[p] = d.vcdt10[p];
			else
				d.vcdt_out[p] = d.vcdt12[p];
		end

		// A port reaches the monitor pins only when all four steps are done: enable, mux, loop select, CML enable
		d.mon_out = d.mon_en ? (d.mon_mux & d.loop_sel & d.cml_en) : 4'h0;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			q          <= '0;
			q.fwd      <= RST_FWD;
			q.vcdt10   <= {4{RST_VCDT_TEN}};
			q.vcdt12   <= {4{RST_VCDT_TWELVE}};
			q.vcdt_out <= {4{RST_VCDT_TWELVE}};
			q.eq_ctl   <= {4{RST_EQ_CTRL}};
		end
		else
			q <= d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o                  = q.rdata;
	assign strap_done_o                 = q.strap_done;
	assign raw_vc_dt_o                  = q.vcdt_out;
	assign fwd_enable_o                 = q.fwd[3:0];
	assign fwd_target_o                 = q.fwd[7:4];
	assign eq_level_o                   = q.eq_lvl;
	assign adaptive_equalizer_restart_o = q.restart;
	assign monitor_output_enable_o      = q.mon_en;
	assign monitor_port_o               = q.mon_out;

	always_comb
	begin
		for (int p = 0; p < 4; p++)
		begin
			link_input_mode_o[p]   = q.cfg[p][1:0];
			cable_type_select_o[p] = q.cfg[p][CFG_CABLE_BIT];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_strap_load;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(q.strap_done) |-> q.cfg[3][2:0] == $past(q.strap_s2);
	endproperty
	a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

	property p_cfg_write;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == ADDR_PORT_CFG && q.port_sel == 2'h0 && q.strap_done
		|=> link_input_mode_o[0] == $past(reg_wdata_i[1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("mode write lost");

	property p_port_isolation;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == ADDR_PORT_CFG && q.port_sel == 2'h0 && q.strap_done
		|=> $stable(q.cfg[1]) && $stable(q.cfg[2]) && $stable(q.cfg[3]);
	endproperty
	a_port_isolation: assert property (p_port_isolation) else $error("other port hit");

	property p_lock_restart;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		$fell(q.lock_s2[2]) |=> adaptive_equalizer_restart_o[2]
			##1 !adaptive_equalizer_restart_o[2];
	endproperty
	a_lock_restart: assert property (p_lock_restart) else $error("no eq restart");

	property p_eq_hold;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		q.lock_s2[0] && q.lock_d[0] |=> $stable(eq_level_o[0]);
	endproperty
	a_eq_hold: assert property (p_eq_hold) else $error("eq moved while locked");

	property p_tick_gap;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		q.tick |=> (!q.tick) [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("timer too fast");

	property p_fwd;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == ADDR_FWD
		|=> fwd_target_o == $past(reg_wdata_i[7:4]) && fwd_enable_o == $past(reg_wdata_i[3:0]);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forwarding not taken");

	property p_mon_enable;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		reg_wr_i && reg_addr_i == ADDR_DATA && q.page == PAGE_SHARED && q.idx == IDX_MON_EN
		|=> monitor_output_enable_o == $past(reg_wdata_i[MON_EN_BIT]);
	endproperty
	a_mon_enable: assert property (p_mon_enable) else $error("indirect write lost");

	property p_vcdt;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		q.cfg[0][1:0] == MODE_TEN && $stable(q.cfg[0]) && $stable(q.vcdt10[0])
		|-> raw_vc_dt_o[0] == q.vcdt10[0];
	endproperty
	a_vcdt: assert property (p_vcdt) else $error("header byte wrong");

endmodule

// [hub_host_model.sv]
// Purpose: Host model that programs the hub register port
// Assumes: Strobes launch 1 ns after the rising edge of ref_clk_i
// Notes:   Indirect sequences keep the page, index, data order

`timescale 1ns/100ps

module hub_host_model
(
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	initial
	begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_wr_o = 1'b0;
		// Stale data must never pass for a fresh write
		reg_wdata_o = ~d;
		@(posedge ref_clk_i);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		reg_rd_o = 1'b0;
		d = reg_rdata_i;
	endtask

	task automatic mon_route(input logic [1:0] p);
		wr(8'hb0, 8'h14);
		wr(8'hb1, 8'h00);
		wr(8'hb2, 8'h80);
		wr(8'hb1, 8'h01);
		wr(8'hb2, 8'h01 << p);
		wr(8'hb0, 8'h04 + {4'h0, p, 2'h0});
		wr(8'hb1, 8'h0f);
		wr(8'hb2, 8'h01);
		wr(8'hb1, 8'h10);
		wr(8'hb2, 8'h02);
	endtask
endmodule

// [camera_hub_mode_monitor_config_tb.sv]
// Purpose: Self-checking bench for the camera hub configuration bank
// Assumes: Host model owns the register port
// Notes:   Each scenario is its own task

`timescale 1ns/100ps

module camera_hub_mode_monitor_config_tb;
	import camera_hub_pkg::*;

	logic            ref_clk_i;
	logic            sys_rst_i;
	logic      [2:0] mode_strap_i;
	logic      [3:0] rx_lock_i;
	logic            reg_wr;
	logic            reg_rd;
	logic      [7:0] reg_addr;
	logic      [7:0] reg_wdata;
	logic      [7:0] reg_rdata_o;
	logic            strap_done_o;
	logic [3:0][1:0] link_input_mode_o;
	logic      [3:0] cable_type_select_o;
	logic [3:0][7:0] raw_vc_dt_o;
	logic      [3:0] fwd_enable_o;
	logic      [3:0] fwd_target_o;
	logic [3:0][7:0] eq_level_o;
	logic      [3:0] adaptive_equalizer_restart_o;
	logic            monitor_output_enable_o;
	logic      [3:0] monitor_port_o;
	int              err_count = 0;
	int              n_checks = 0;
	int              cyc = 0;

	camera_hub_mode_monitor_config camera_hub_mode_monitor_config_inst (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .mode_strap_i(mode_strap_i),
		.rx_lock_i(rx_lock_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
		.strap_done_o(strap_done_o), .link_input_mode_o(link_input_mode_o),
		.cable_type_select_o(cable_type_select_o), .raw_vc_dt_o(raw_vc_dt_o),
		.fwd_enable_o(fwd_enable_o), .fwd_target_o(fwd_target_o),
		.eq_level_o(eq_level_o),
		.adaptive_equalizer_restart_o(adaptive_equalizer_restart_o),
		.monitor_output_enable_o(monitor_output_enable_o), .monitor_port_o(monitor_port_o));

	hub_host_model hub_host_model_inst (
		.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

	// ----------------------------------------
	// Clock, timeout, helpers
	// ----------------------------------------
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		hub_host_model_inst.wr(a, d);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_strap;
		logic [2:0] c;
		logic [7:0] d;
		int         k;
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			mode_strap_i = c;
			sys_rst_i = 1'b1;
			repeat (4) @(posedge ref_clk_i);
			#1;
			chk(fwd_enable_o, 32'hf);
			chk(raw_vc_dt_o, {4{8'h2c}});
			sys_rst_i = 1'b0;
			k = 0;
			while (strap_done_o !== 1'b1 && k < 10)
			begin
				@(posedge ref_clk_i);
				#1;
				k++;
			end
			chk(k, 3);
			chk(link_input_mode_o, {4{c[1:0]}});
			chk(cable_type_select_o, {4{c[2]}});
		end
		hub_host_model_inst.rd(8'h6d, d);
		chk(d, 8'h07);
		// Read data stands one cycle only
		@(posedge ref_clk_i);
		#1;
		chk(reg_rdata_o, 8'h00);
	endtask

	task automatic t_port_cfg;
		wr(8'h4c, 8'h01);
		wr(8'h6d, 8'h01);
		chk(link_input_mode_o, 8'hf7);
		chk(cable_type_select_o, 4'hd);
		wr(8'h4c, 8'h00);
		wr(8'h6d, 8'h0b);
		chk(link_input_mode_o, 8'hf7);
		chk(cable_type_select_o, 4'hc);
		wr(8'h70, 8'h55);
		chk(raw_vc_dt_o, 32'h2b2b2c55);
	endtask

	task automatic t_fwd;
		logic [7:0] d;
		wr(8'h20, 8'ha5);
		chk(fwd_enable_o, 4'h5);
		chk(fwd_target_o, 4'ha);
		hub_host_model_inst.rd(8'hff, d);
		chk(d, 8'h00);
	endtask

	task automatic t_lock;
		logic [7:0] d;
		int         k;
		wr(8'h4c, 8'h02);
		wr(8'hd4, 8'h05);
		rx_lock_i = 4'hb;
		k = 0;
		while (adaptive_equalizer_restart_o !== 4'h4 && k < 10)
		begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
		chk(k, 3);
		chk(eq_level_o[2], 8'h05);
		hub_host_model_inst.rd(8'hd2, d);
		chk(d[7], 1'b0);
		repeat (300) @(posedge ref_clk_i);
		#1;
		chk(eq_level_o[2] == 8'h06 || eq_level_o[2] == 8'h07, 1'b1);
		rx_lock_i = 4'hf;
		repeat (10) @(posedge ref_clk_i);
		#1;
		d = eq_level_o[2];
		repeat (300) @(posedge ref_clk_i);
		#1;
		chk(eq_level_o[2], d);
	endtask

	task automatic t_monitor;
		wr(8'hb0, 8'h15);
		wr(8'hb1, 8'h00);
		wr(8'hb2, 8'h80);
		chk(monitor_output_enable_o, 1'b0);
		hub_host_model_inst.mon_route(2'd3);
		chk(monitor_output_enable_o, 1'b1);
		chk(monitor_port_o, 4'h8);
		hub_host_model_inst.mon_route(2'd1);
		chk(monitor_port_o, 4'h2);
	endtask

	initial
	begin
		sys_rst_i = 1'b1;
		mode_strap_i = 3'h0;
		rx_lock_i = 4'hf;
		t_strap();
		t_port_cfg();
		t_fwd();
		t_lock();
		t_monitor();
		stop_test();
	end
endmodule
